//--- vhwp_params.svh
// Register offsets, field positions, reset values and memory map of the video memory write port
`ifndef VHWP_PARAMS_SVH
`define VHWP_PARAMS_SVH

// ****************************************************************
// Host register word offsets
// ****************************************************************
`define VHWP_OFF_CTRL   2'h0
`define VHWP_OFF_ADDR   2'h1
`define VHWP_OFF_LOW    2'h2
`define VHWP_OFF_HIGH   2'h3

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define VHWP_CTRL_RST       32'h00000000
`define VHWP_CTRL_IRQ_BIT   31
`define VHWP_CTRL_WRALL_BIT 30
`define VHWP_STEP_MSB       15

// ****************************************************************
// Virtual map: region selector is address bits 31..28
// ****************************************************************
`define VHWP_REGION_MSB  31
`define VHWP_REGION_LSB  28
`define VHWP_BASE_TB     4'h0
`define VHWP_BASE_TG     4'h1
`define VHWP_BASE_SG     4'h2
`define VHWP_BASE_PAL    4'h3
`define VHWP_BASE_SATTR  4'h4
`define VHWP_SIZE_TB     28'h00004b0
`define VHWP_SIZE_TG     28'h0004000
`define VHWP_SIZE_SG     28'h0004000
`define VHWP_SIZE_PAL    28'h0000400
`define VHWP_SIZE_SATTR  28'h0000400

// ****************************************************************
// Memory data widths and index width
// ****************************************************************
`define VHWP_W_TB    16
`define VHWP_W_PAL   24
`define VHWP_W_SATTR 16
`define VHWP_IDX_W   14

`endif

//--- vhwp_pkg.sv
// Types shared by the video memory write port modules
package vhwp_pkg;

	// ****************************************************************
	// Target memories, bit position of each in the write enable vector
	// ****************************************************************
	typedef enum logic [2:0] {
		TGT_TILE_BUF = 3'h0,
		TGT_TILE_GFX = 3'h1,
		TGT_SPR_GFX  = 3'h2,
		TGT_PALETTE  = 3'h3,
		TGT_SPR_ATTR = 3'h4,
		TGT_NONE     = 3'h7
	} vhwp_tgt_t;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic        wr;
		logic [1:0]  reg_idx;
		logic [31:0] data;
	} vhwp_req_t;

	typedef struct packed {
		logic [4:0]  we;
		logic [13:0] idx;
		logic [63:0] data;
	} vhwp_mem_wr_t;

	typedef struct packed {
		logic [31:0]  ctrl;
		logic [31:0]  vaddr;
		logic [31:0]  data_hi;
		vhwp_mem_wr_t mem;
		logic         irq;
		logic         dropped;
	} vhwp_state_t;

endpackage : vhwp_pkg

//--- vhwp_decode.sv
// Virtual video memory address decoder
`timescale 1ns/1ps
`include "vhwp_params.svh"

module vhwp_decode #(
	parameter int IDX_W = `VHWP_IDX_W
) (
	// Virtual address
	input  wire logic [31:0]       vaddr,
	// Decoded target
	output vhwp_pkg::vhwp_tgt_t    tgt,
	output logic [IDX_W-1:0]       idx,
	output logic                   hit
);

	// Largest memory needs the full index width
	if (IDX_W < `VHWP_IDX_W) begin : g_bad_idx
		$error("vhwp_decode: IDX_W too small");
	end

	logic [3:0]  region;
	logic [27:0] offs;

	assign region = vaddr[`VHWP_REGION_MSB:`VHWP_REGION_LSB];
	assign offs   = vaddr[`VHWP_REGION_LSB-1:0];
	assign idx    = offs[IDX_W-1:0];

	// Region select and bound check; addresses past a memory's end hit nothing
	always_comb begin
		tgt = vhwp_pkg::TGT_NONE;
		hit = 1'b0;
		unique case (region)
			`VHWP_BASE_TB: begin
				tgt = vhwp_pkg::TGT_TILE_BUF;
				hit = offs < `VHWP_SIZE_TB;
			end
			`VHWP_BASE_TG: begin
				tgt = vhwp_pkg::TGT_TILE_GFX;
				hit = offs < `VHWP_SIZE_TG;
			end
			`VHWP_BASE_SG: begin
				tgt = vhwp_pkg::TGT_SPR_GFX;
				hit = offs < `VHWP_SIZE_SG;
			end
			`VHWP_BASE_PAL: begin
				tgt = vhwp_pkg::TGT_PALETTE;
				hit = offs < `VHWP_SIZE_PAL;
			end
			`VHWP_BASE_SATTR: begin
				tgt = vhwp_pkg::TGT_SPR_ATTR;
				hit = offs < `VHWP_SIZE_SATTR;
			end
			default: begin
				tgt = vhwp_pkg::TGT_NONE;
				hit = 1'b0;
			end
		endcase
	end

endmodule : vhwp_decode

//--- vhwp_pack.sv
// Shapes the two host data halves to the width of the target memory
`timescale 1ns/1ps
`include "vhwp_params.svh"

module vhwp_pack (
	// Target and host halves
	input  wire vhwp_pkg::vhwp_tgt_t tgt,
	input  wire logic [31:0]         lo,
	input  wire logic [31:0]         hi,
	// Word for the memory
	output logic [63:0]              word
);

	// Upper half only reaches the graphics memories; narrow ones lose top bits
	always_comb begin
		word = 64'h0;
		unique case (tgt)
			vhwp_pkg::TGT_TILE_GFX,
			vhwp_pkg::TGT_SPR_GFX: word = {hi, lo};
			vhwp_pkg::TGT_TILE_BUF: word[`VHWP_W_TB-1:0] = lo[`VHWP_W_TB-1:0];
			vhwp_pkg::TGT_PALETTE: word[`VHWP_W_PAL-1:0] = lo[`VHWP_W_PAL-1:0];
			vhwp_pkg::TGT_SPR_ATTR: word[`VHWP_W_SATTR-1:0] = lo[`VHWP_W_SATTR-1:0];
			default: word = 64'h0;
		endcase
	end

endmodule : vhwp_pack

//--- vhwp_port.sv
// Host write port into the virtual video memory of the picture unit
//
// Notes on behaviour
// - Region 0x0 reaches the tile buffer, 1200 entries of 16 bits.
// - Region 0x1 reaches tile graphics, 16384 entries of 64 bits.
// - Region 0x2 reaches sprite graphics, 16384 entries of 64 bits.
// - Region 0x3 reaches colour palettes, 1024 entries of 24 bits.
// - Region 0x4 reaches sprite attributes, 1024 entries of 16 bits.
// - Host path is 32 bits; separate low and high data registers.
// - Control bits 15..0 are the step; zero turns auto-increment off.
// - Control bit 31 enables the vertical-blank interrupt.
// - Control bit 30 allows memory writes outside vertical blank.
// - A low data write starts a memory write at the current address.
// - After such a write the address grows by the nonzero step.
// - The high half is used only for the two graphics memories.
// - Narrow memories keep only the low bits of the low half.
// - Vertical-blank interrupt goes out on the interrupt line when enabled.
// - Address register is virtual; all four registers are write-only.
`timescale 1ns/1ps
`include "vhwp_params.svh"

module vhwp_port (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Host register port, write only
	input  wire vhwp_pkg::vhwp_req_t    host_req,
	// Display timing
	input  wire logic                   in_vblank,
	// Video memory write port
	output vhwp_pkg::vhwp_mem_wr_t      mem_wr,
	// Host status
	output logic                        host_irq,
	output logic                        wr_dropped
);

	// ****************************************************************
	// State and decode
	// ****************************************************************
	vhwp_pkg::vhwp_state_t st_r;
	vhwp_pkg::vhwp_state_t st_nxt;

	vhwp_pkg::vhwp_tgt_t   dec_tgt;
	logic [13:0]           dec_idx;
	logic                  dec_hit;
	logic [63:0]           packed_word;
	logic [15:0]           step;
	logic                  wr_allowed;
	logic                  low_wr;

	// Current address picks the target memory
	vhwp_decode #(
		.IDX_W (`VHWP_IDX_W)
	) u_decode (
		.vaddr (st_r.vaddr),
		.tgt   (dec_tgt),
		.idx   (dec_idx),
		.hit   (dec_hit)
	);

	// Incoming low half plus stored high half, cut to the target width
	vhwp_pack u_pack (
		.tgt  (dec_tgt),
		.lo   (host_req.data),
		.hi   (st_r.data_hi),
		.word (packed_word)
	);

	// Control fields
	assign step       = st_r.ctrl[`VHWP_STEP_MSB:0];
	assign wr_allowed = in_vblank | st_r.ctrl[`VHWP_CTRL_WRALL_BIT];
	assign low_wr     = host_req.wr && (host_req.reg_idx == `VHWP_OFF_LOW);

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Write enables and the drop flag are single-cycle pulses
	always_comb begin
		st_nxt         = st_r;
		st_nxt.mem.we  = 5'h00;
		st_nxt.dropped = 1'b0;
		// Interrupt follows vertical blank only while enabled
		st_nxt.irq = st_r.ctrl[`VHWP_CTRL_IRQ_BIT] & in_vblank;
		if (host_req.wr) begin
			// Registers are write only, so there is no read path
			unique case (host_req.reg_idx)
				`VHWP_OFF_CTRL: st_nxt.ctrl = host_req.data;
				`VHWP_OFF_ADDR: st_nxt.vaddr = host_req.data;
				`VHWP_OFF_HIGH: st_nxt.data_hi = host_req.data;
				`VHWP_OFF_LOW: begin
					if (wr_allowed) begin
						// Unmapped addresses write nothing but still advance
						if (dec_hit) begin
							st_nxt.mem.we   = 5'h01 << dec_tgt;
							st_nxt.mem.idx  = dec_idx;
							st_nxt.mem.data = packed_word;
						end
						if (step != 16'h0000) begin
							st_nxt.vaddr = st_r.vaddr + {16'h0000, step};
						end
					end else begin
						// Display is reading: drop it, keep the address
						st_nxt.dropped = 1'b1;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Control clears at reset so writes are blocked outside vertical blank and the interrupt is off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r         <= '0;
			st_r.ctrl    <= `VHWP_CTRL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the state flops
	assign mem_wr     = st_r.mem;
	assign host_irq   = st_r.irq;
	assign wr_dropped = st_r.dropped;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic hit_wr;
	assign hit_wr = low_wr && wr_allowed && dec_hit;

	chk_low_starts_write: assert property (
		hit_wr |=> $onehot(mem_wr.we) && mem_wr.idx == $past(dec_idx)
	) else $error("low write did not start a memory write");

	chk_only_from_low: assert property (
		mem_wr.we != 5'h00 |-> $past(low_wr)
	) else $error("memory write without a low data write");

	chk_step_added: assert property (
		low_wr && wr_allowed && step != 16'h0000
			|=> st_r.vaddr == $past(st_r.vaddr) + {16'h0000, $past(step)}
	) else $error("address not advanced by the step");

	chk_zero_step_hold: assert property (
		low_wr && step == 16'h0000 |=> $stable(st_r.vaddr)
	) else $error("address moved with auto-increment off");

	chk_tile_buf_map: assert property (
		mem_wr.we[0] |-> $past(st_r.vaddr[31:28]) == 4'h0
			&& $past(st_r.vaddr[27:0]) < 28'h00004b0
	) else $error("tile buffer write outside its region");

	chk_tile_gfx_map: assert property (
		mem_wr.we[1] |-> $past(st_r.vaddr[31:14]) == 18'h04000
	) else $error("tile graphics write outside its region");

	chk_spr_gfx_map: assert property (
		mem_wr.we[2] |-> $past(st_r.vaddr[31:14]) == 18'h08000
	) else $error("sprite graphics write outside its region");

	chk_palette_map: assert property (
		mem_wr.we[3] |-> $past(st_r.vaddr[31:10]) == 22'h0c0000
	) else $error("palette write outside its region");

	chk_attr_map: assert property (
		mem_wr.we[4] |-> $past(st_r.vaddr[31:10]) == 22'h100000
	) else $error("sprite attribute write outside its region");

	chk_high_half_use: assert property (
		(mem_wr.we[1] || mem_wr.we[2])
			|-> mem_wr.data == {$past(st_r.data_hi), $past(host_req.data)}
	) else $error("graphics word not built from both halves");

	chk_narrow_trunc: assert property (
		(mem_wr.we[0] || mem_wr.we[4]) |-> mem_wr.data[63:16] == 48'h0
			&& mem_wr.data[15:0] == $past(host_req.data[15:0])
	) else $error("16-bit write not truncated");

	chk_palette_trunc: assert property (
		mem_wr.we[3] |-> mem_wr.data[63:24] == 40'h0
			&& mem_wr.data[23:0] == $past(host_req.data[23:0])
	) else $error("palette write not truncated");

	chk_high_stored: assert property (
		host_req.wr && host_req.reg_idx == `VHWP_OFF_HIGH
			|=> st_r.data_hi == $past(host_req.data)
	) else $error("high half not stored");

	chk_blocked_drop: assert property (
		low_wr && !in_vblank && !st_r.ctrl[30]
			|=> mem_wr.we == 5'h00 && wr_dropped && $stable(st_r.vaddr)
	) else $error("blocked write was not dropped");

	chk_open_write: assert property (
		low_wr && dec_hit && st_r.ctrl[30] |=> mem_wr.we != 5'h00
	) else $error("open write was refused in active display");

	chk_irq_follows: assert property (
		##1 host_irq == ($past(st_r.ctrl[31]) && $past(in_vblank))
	) else $error("interrupt line does not follow blank and enable");

	chk_irq_masked: assert property (
		!st_r.ctrl[31] [*2] |-> !host_irq
	) else $error("interrupt raised while disabled");

	chk_ctrl_reset: assert property (
		@(posedge clk) disable iff (1'b0)
		!rst_n |=> st_r.ctrl == 32'h0 && !host_irq && mem_wr.we == 5'h00
	) else $error("control not cleared by reset");

	// ****************************************************************
	// Register storage, drop, interrupt and bound checks
	// ****************************************************************
	chk_ctrl_stored: assert property (
		host_req.wr && host_req.reg_idx == `VHWP_OFF_CTRL
			|=> st_r.ctrl == $past(host_req.data)
	) else $error("control word not stored");

	chk_addr_stored: assert property (
		host_req.wr && host_req.reg_idx == `VHWP_OFF_ADDR
			|=> st_r.vaddr == $past(host_req.data)
	) else $error("address word not stored");

	chk_high_held: assert property (
		!(host_req.wr && host_req.reg_idx == `VHWP_OFF_HIGH) |=> $stable(st_r.data_hi)
	) else $error("high half changed without a high write");

	chk_we_onehot: assert property (
		mem_wr.we != 5'h00 |-> $onehot(mem_wr.we)
	) else $error("more than one memory written at once");

	// Index and word must hold between writes; the memories may sample late
	chk_word_held: assert property (
		!hit_wr |=> $stable(mem_wr.idx) && $stable(mem_wr.data)
	) else $error("memory index or word moved without a write");

	chk_unmapped_quiet: assert property (
		low_wr && wr_allowed && !dec_hit |=> mem_wr.we == 5'h00 && !wr_dropped
	) else $error("unmapped write reached a memory or was flagged");

	chk_drop_cause: assert property (
		wr_dropped |-> $past(low_wr) && !$past(wr_allowed)
	) else $error("drop flagged without a blocked low write");

	chk_open_no_drop: assert property (
		low_wr && st_r.ctrl[`VHWP_CTRL_WRALL_BIT] |=> !wr_dropped
	) else $error("write dropped although writes were open");

	chk_blank_write: assert property (
		low_wr && in_vblank && dec_hit |=> mem_wr.we != 5'h00
	) else $error("write refused during vertical blank");

	chk_irq_needs_blank: assert property (
		host_irq |-> $past(in_vblank)
	) else $error("interrupt raised outside vertical blank");

	chk_irq_needs_en: assert property (
		host_irq |-> $past(st_r.ctrl[`VHWP_CTRL_IRQ_BIT])
	) else $error("interrupt raised without its enable");

	// Bounds are rechecked on the index so a decode slip shows up here too
	chk_tile_buf_size: assert property (
		mem_wr.we[0] |-> mem_wr.idx < 14'h04b0
	) else $error("tile buffer index past its last entry");

	chk_palette_size: assert property (
		mem_wr.we[3] |-> mem_wr.idx < 14'h0400
	) else $error("palette index past its last entry");

	chk_attr_size: assert property (
		mem_wr.we[4] |-> mem_wr.idx < 14'h0400
	) else $error("sprite attribute index past its last entry");

	// Graphics bursts interleave a high write, so low writes land every other cycle
	cov_burst: cover property (
		hit_wr ##2 hit_wr ##2 hit_wr
	);

	cov_gfx_write: cover property (
		mem_wr.we[1] || mem_wr.we[2]
	);

	cov_dropped: cover property (
		wr_dropped
	);

	cov_irq: cover property (
		$rose(host_irq)
	);

	cov_unmapped: cover property (
		low_wr && wr_allowed && !dec_hit
	);

endmodule : vhwp_port

//--- vhwp_host_model.sv
// Behavioural host processor that writes the port's registers
`timescale 1ns/1ps

module vhwp_host_model (
	// Clock
	input  wire logic           clk,
	// Register writes toward the port
	output vhwp_pkg::vhwp_req_t host_req
);

	// ****************************************************************
	// Bus driver
	// ****************************************************************

	// Idle bus from time zero
	initial host_req = '0;

	// Strobe up for one cycle, then an idle release cycle; hold keeps the strobe up for a back-to-back follower
	task automatic wr(input logic [1:0] idx, input logic [31:0] d, input bit hold = 0);
		host_req = {1'b1, idx, d};
		@(negedge clk);
		if (!hold) rel();
	endtask : wr

	// Released data is inverted so a stale word never looks valid
	task automatic rel();
		host_req.wr   = 1'b0;
		host_req.data = ~host_req.data;
		@(negedge clk);
	endtask : rel

endmodule : vhwp_host_model

//--- tb_vhwp_port.sv
// Self-checking testbench for the video memory write port
`timescale 1ns/1ps

module tb_vhwp_port;

	// ****************************************************************
	// Signals
	// ****************************************************************
	typedef struct {
		logic [31:0] a;
		logic [31:0] hi;
		logic [31:0] lo;
		logic [4:0]  we;
		logic [13:0] ix;
		logic [63:0] dt;
	} vhwp_row_t;

	logic                   clk          = 1'b0;
	logic                   rst_n        = 1'b0;
	logic                   in_vblank    = 1'b0;
	vhwp_pkg::vhwp_req_t    host_req;
	vhwp_pkg::vhwp_mem_wr_t mem_wr;
	logic                   host_irq;
	logic                   wr_dropped;
	int                     mismatches   = 0;
	int                     total_checks = 0;
	vhwp_row_t              rows [5];
	logic [31:0]            hv;
	logic [31:0]            lv;
	logic [31:0]            bad [3];

	// 50 MHz clock
	always #10 clk = ~clk;

	vhwp_port i_vhwp_port (
		.clk        (clk),
		.rst_n      (rst_n),
		.host_req   (host_req),
		.in_vblank  (in_vblank),
		.mem_wr     (mem_wr),
		.host_irq   (host_irq),
		.wr_dropped (wr_dropped)
	);

	vhwp_host_model i_vhwp_host_model (
		.clk      (clk),
		.host_req (host_req)
	);

	// ****************************************************************
	// Tasks
	// ****************************************************************

	// Count one comparison, report it at once if it misses
	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	// Low half write; the result is looked at in the cycle after the taking edge
	task automatic lo(input logic [31:0] d, input logic [4:0] we, input logic [13:0] ix,
		input logic [63:0] dt, input logic dr, input bit hold = 0);
		i_vhwp_host_model.wr(2'h2, d, 1'b1);
		chk(mem_wr.we === we && wr_dropped === dr, "write strobe");
		if (we != 5'h00) chk(mem_wr.idx === ix && mem_wr.data === dt, "write word");
		if (!hold) i_vhwp_host_model.rel();
	endtask : lo

	// Single place where the run ends
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	// Hang guard: a run that overstays counts as a miss
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		finish_test();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		rows[0] = '{32'h000004af, 32'h11111111, 32'hdeadbeef, 5'h01, 14'h04af, 64'h000000000000beef};
		rows[1] = '{32'h10003fff, 32'h01234567, 32'h89abcdef, 5'h02, 14'h3fff, 64'h0123456789abcdef};
		rows[2] = '{32'h20000000, 32'hfedcba98, 32'h76543210, 5'h04, 14'h0000, 64'hfedcba9876543210};
		rows[3] = '{32'h300003ff, 32'h11111111, 32'hdeadbeef, 5'h08, 14'h03ff, 64'h0000000000adbeef};
		rows[4] = '{32'h40000001, 32'h22222222, 32'hcafef00d, 5'h10, 14'h0001, 64'h000000000000f00d};
		bad     = '{32'h000004b0, 32'h30000400, 32'h50000000};
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		chk(mem_wr.we === 5'h00 && host_irq === 1'b0 && wr_dropped === 1'b0, "reset");
		// Cleared control blocks writes in active display; address must not move
		i_vhwp_host_model.wr(2'h1, 32'h00000005);
		lo(32'h0000abcd, 5'h00, 14'h0000, 64'h0, 1'b1);
		i_vhwp_host_model.wr(2'h0, 32'h00000001);
		lo(32'h0000abcd, 5'h00, 14'h0000, 64'h0, 1'b1);
		in_vblank = 1'b1;
		lo(32'h0000abcd, 5'h01, 14'h0005, 64'h000000000000abcd, 1'b0);
		lo(32'h00001234, 5'h01, 14'h0006, 64'h0000000000001234, 1'b0);
		// One word into each memory, then a second into sprite attributes, with writes opened outside blank
		in_vblank = 1'b0;
		i_vhwp_host_model.wr(2'h0, 32'h40000000);
		foreach (rows[i]) begin
			i_vhwp_host_model.wr(2'h1, rows[i].a);
			i_vhwp_host_model.wr(2'h3, rows[i].hi);
			lo(rows[i].lo, rows[i].we, rows[i].ix, rows[i].dt, 1'b0);
		end
		lo(32'h00000777, 5'h10, 14'h0001, 64'h0000000000000777, 1'b0);
		// Back-to-back burst with step three, address written once
		i_vhwp_host_model.wr(2'h0, 32'h40000003);
		i_vhwp_host_model.wr(2'h1, 32'h10000010);
		for (int k = 0; k < 3; k++) begin
			hv = 32'ha0000000 + 32'(k);
			lv = 32'hb0000000 + 32'(k);
			i_vhwp_host_model.wr(2'h3, hv, 1'b1);
			lo(lv, 5'h02, 14'(16 + 3 * k), {hv, lv}, 1'b0, k < 2);
		end
		// Past the end of a memory or outside the map nothing is written
		foreach (bad[i]) begin
			i_vhwp_host_model.wr(2'h1, bad[i]);
			lo(32'h00000001, 5'h00, 14'h0000, 64'h0, 1'b0);
		end
		// Interrupt follows enable and blank
		in_vblank = 1'b1;
		i_vhwp_host_model.wr(2'h0, 32'h80000000);
		chk(host_irq === 1'b1, "irq on");
		in_vblank = 1'b0;
		@(negedge clk);
		chk(host_irq === 1'b0, "irq after blank");
		in_vblank = 1'b1;
		i_vhwp_host_model.wr(2'h0, 32'h00000000);
		chk(host_irq === 1'b0, "irq masked");
		// Second reset in mid-run clears control again
		i_vhwp_host_model.wr(2'h0, 32'hc0000001);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk(host_irq === 1'b0, "irq after reset");
		in_vblank = 1'b0;
		i_vhwp_host_model.wr(2'h1, 32'h00000005);
		lo(32'h00000042, 5'h00, 14'h0000, 64'h0, 1'b1);
		finish_test();
	end

endmodule : tb_vhwp_port
